// file: hw/swc_defs.svh
// Constants for the sleep and wake controller
`ifndef SWC_DEFS_SVH
`define SWC_DEFS_SVH
`define SWC_REG_OFFSET_REGCTL 4'h0
`define SWC_REG_OFFSET_STATUS 4'h1
`define SWC_REG_OFFSET_CONFIG 4'h2
`define SWC_REGCTL_PM_BIT 1
`define SWC_REGCTL_RSVD_BIT 0
`define SWC_REGCTL_RESET 8'h01
`define SWC_STATUS_TO_BIT 4
`define SWC_STATUS_PD_BIT 3
`define SWC_OST_PERIODS 1024
`define SWC_OST_CYCLES 11'h400
`define SWC_REG_STAB_NS 20000
`define SWC_REG_STAB_CYCLES (((`SWC_REG_STAB_NS) + 99) / 100)
`define SWC_VECTOR_ADDR 16'h0004
`endif

// file: hw/swc_pkg.sv
// Types for the sleep and wake controller
package swc_pkg;
  typedef enum logic [2:0] {
    SWC_RUN,
    SWC_SLEEP,
    SWC_OST_WAIT,
    SWC_REG_WAIT,
    SWC_RESUME
  } swc_state_t;

  typedef struct packed {
    logic external_reset_pin_en;
    logic external_reset_pin;
    logic bor_en;
    logic bor;
    logic por;
  } swc_reset_src_t;

  typedef struct packed {
    logic wdt_en_sleep;
    logic xtal_mode;
    logic two_speed;
    logic unregulated;
  } swc_cfg_t;
endpackage : swc_pkg

// file: hw/swc_top.sv
// Sleep and wake sequencer with regulator mode control
//
// Chosen here: the strobed register port and the address map.
`include "swc_defs.svh"

module swc_top (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic SLEEP_EXEC_I,
  input wire logic [7:0] INT_PEND_I,
  input wire logic [7:0] INT_EN_I,
  input wire logic GIE_I,
  input wire logic WDT_TIMEOUT_I,
  input wire logic LPSAFE_BLOCK_I,
  input wire logic [2:0] T1_SRC_I,
  input wire logic ADC_RC_SEL_I,
  input wire swc_pkg::swc_reset_src_t RST_SRC_I,
  input wire swc_pkg::swc_cfg_t CFG_I,
  input wire logic [7:0] PIN_OUT_I,
  input wire logic [7:0] PIN_OE_I,
  input wire logic [3:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  output logic CPU_CLK_EN_O,
  output logic SLEEPING_O,
  output logic PD_FLAG_O,
  output logic TO_FLAG_O,
  output logic WDT_CLR_O,
  output logic WDT_RUN_O,
  output logic DEV_RESET_O,
  output logic PREFETCH_O,
  output logic FORCE_VECTOR_O,
  output logic [15:0] VECTOR_ADDR_O,
  output logic LFOSC_EN_O,
  output logic T1_RUN_O,
  output logic ADC_RUN_O,
  output logic REG_LP_O,
  output logic [7:0] PIN_OUT_O,
  output logic [7:0] PIN_OE_O
);
  swc_pkg::swc_state_t state_reg;
  swc_pkg::swc_state_t state_next;
  swc_pkg::swc_reset_src_t rst_s1_reg;
  swc_pkg::swc_reset_src_t rst_s2_reg;
  logic [7:0] pend_s1_reg;
  logic [7:0] pend_s2_reg;
  logic wdt_s1_reg;
  logic wdt_s2_reg;
  logic [15:0] cnt_reg;
  logic regpm_reg;
  logic lp_used_reg;
  logic resumed_reg;
  logic wake_int;
  logic wake_rst;
  logic wake_wdt;
  logic lp_allowed;

  localparam logic [15:0] OST_CNT = 16'(`SWC_OST_CYCLES);
  localparam logic [15:0] STAB_CNT = 16'(`SWC_REG_STAB_CYCLES);

  function automatic logic any_enabled(input logic [7:0] p, input logic [7:0] e);
    any_enabled = |(p & e);
  endfunction : any_enabled

  // Wake sources arrive from other domains
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rst_s1_reg <= '0;
      rst_s2_reg <= '0;
      pend_s1_reg <= 8'h00;
      pend_s2_reg <= 8'h00;
      wdt_s1_reg <= 1'b0;
      wdt_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= RST_SRC_I;
      rst_s2_reg <= rst_s1_reg;
      pend_s1_reg <= INT_PEND_I;
      pend_s2_reg <= pend_s1_reg;
      wdt_s1_reg <= WDT_TIMEOUT_I;
      wdt_s2_reg <= wdt_s1_reg;
    end
  end

  // Reset-type wakes are identical whether asleep or not
  assign wake_rst = (rst_s2_reg.external_reset_pin_en & rst_s2_reg.external_reset_pin) | (rst_s2_reg.bor_en & rst_s2_reg.bor)
                    | rst_s2_reg.por;
  assign wake_int = any_enabled(pend_s2_reg, INT_EN_I);
  assign wake_wdt = wdt_s2_reg & CFG_I.wdt_en_sleep;
  assign lp_allowed = regpm_reg & ~LPSAFE_BLOCK_I & ~CFG_I.unregulated;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      swc_pkg::SWC_RUN: begin
        if (SLEEP_EXEC_I && !(wake_int && !GIE_I)) begin
          state_next = swc_pkg::SWC_SLEEP;
        end
      end
      swc_pkg::SWC_SLEEP: begin
        if (wake_int || wake_wdt) begin
          state_next = CFG_I.xtal_mode && !CFG_I.two_speed ? swc_pkg::SWC_OST_WAIT
                       : (lp_used_reg ? swc_pkg::SWC_REG_WAIT : swc_pkg::SWC_RESUME);
        end
      end
      swc_pkg::SWC_OST_WAIT: begin
        if (cnt_reg == 16'h0001) begin
          state_next = lp_used_reg ? swc_pkg::SWC_REG_WAIT : swc_pkg::SWC_RESUME;
        end
      end
      swc_pkg::SWC_REG_WAIT: begin
        if (cnt_reg == 16'h0001) begin
          state_next = swc_pkg::SWC_RESUME;
        end
      end
      swc_pkg::SWC_RESUME: begin
        state_next = swc_pkg::SWC_RUN;
      end
    endcase
    if (wake_rst) begin
      state_next = swc_pkg::SWC_RUN;
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_reg <= swc_pkg::SWC_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // Delay counter loaded on each wait entry
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      cnt_reg <= 16'h0000;
    end else if (state_next == swc_pkg::SWC_OST_WAIT && state_reg != swc_pkg::SWC_OST_WAIT) begin
      cnt_reg <= OST_CNT;
    end else if (state_next == swc_pkg::SWC_REG_WAIT && state_reg != swc_pkg::SWC_REG_WAIT) begin
      cnt_reg <= STAB_CNT;
    end else if (cnt_reg != 16'h0000) begin
      cnt_reg <= cnt_reg - 16'h0001;
    end
  end

  // Low-power choice latched at entry so a later write cannot change the wake delay
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      lp_used_reg <= 1'b0;
    end else if (state_reg == swc_pkg::SWC_RUN && state_next == swc_pkg::SWC_SLEEP) begin
      lp_used_reg <= lp_allowed;
    end
  end

  // Status flags: power-down low and time-out high after a real sleep
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      PD_FLAG_O <= 1'b1;
      TO_FLAG_O <= 1'b1;
    end else if (wake_rst) begin
      PD_FLAG_O <= 1'b1;
      TO_FLAG_O <= 1'b1;
    end else if (state_reg == swc_pkg::SWC_RUN && state_next == swc_pkg::SWC_SLEEP) begin
      PD_FLAG_O <= 1'b0;
      TO_FLAG_O <= 1'b1;
    end else if (state_reg == swc_pkg::SWC_SLEEP && wake_wdt && !wake_int) begin
      TO_FLAG_O <= 1'b0;
    end
  end

  // Watchdog clear pulses on entry and on every wake
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      WDT_CLR_O <= 1'b0;
      WDT_RUN_O <= 1'b1;
    end else begin
      WDT_CLR_O <= (state_reg == swc_pkg::SWC_RUN && state_next == swc_pkg::SWC_SLEEP)
                   || (state_reg == swc_pkg::SWC_SLEEP && state_next != swc_pkg::SWC_SLEEP);
      WDT_RUN_O <= (state_next == swc_pkg::SWC_RUN) || CFG_I.wdt_en_sleep;
    end
  end

  // Clock gating, resets and resume sequencing
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      CPU_CLK_EN_O <= 1'b1;
      SLEEPING_O <= 1'b0;
      DEV_RESET_O <= 1'b0;
      PREFETCH_O <= 1'b0;
      FORCE_VECTOR_O <= 1'b0;
      resumed_reg <= 1'b0;
    end else begin
      CPU_CLK_EN_O <= state_next == swc_pkg::SWC_RUN || state_next == swc_pkg::SWC_RESUME;
      SLEEPING_O <= state_next != swc_pkg::SWC_RUN && state_next != swc_pkg::SWC_RESUME;
      DEV_RESET_O <= wake_rst;
      PREFETCH_O <= state_reg == swc_pkg::SWC_RUN && SLEEP_EXEC_I;
      resumed_reg <= state_reg == swc_pkg::SWC_RESUME;
      FORCE_VECTOR_O <= resumed_reg && GIE_I && !wake_rst;
    end
  end

  assign VECTOR_ADDR_O = `SWC_VECTOR_ADDR;

  // Slow oscillator always on; Timer1 and ADC run in sleep only when T1_SRC_I is non-zero or ADC_RC_SEL_I is set
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      LFOSC_EN_O <= 1'b1;
      T1_RUN_O <= 1'b1;
      ADC_RUN_O <= 1'b1;
      REG_LP_O <= 1'b0;
    end else begin
      LFOSC_EN_O <= 1'b1;
      T1_RUN_O <= state_next == swc_pkg::SWC_RUN || (|T1_SRC_I);
      ADC_RUN_O <= state_next == swc_pkg::SWC_RUN || ADC_RC_SEL_I;
      // At entry the latched choice is not yet loaded, so take the live one
      REG_LP_O <= state_next == swc_pkg::SWC_SLEEP
                  && (state_reg == swc_pkg::SWC_RUN ? lp_allowed : lp_used_reg);
    end
  end

  // Pin state frozen while asleep
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      PIN_OUT_O <= 8'h00;
      PIN_OE_O <= 8'h00;
    end else if (state_next == swc_pkg::SWC_RUN) begin
      PIN_OUT_O <= PIN_OUT_I;
      PIN_OE_O <= PIN_OE_I;
    end
  end

  // Register port: regulator control, status view, config view
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      regpm_reg <= 1'b0;
    end else if (WR_I && ADDR_I == `SWC_REG_OFFSET_REGCTL) begin
      regpm_reg <= WDATA_I[`SWC_REGCTL_PM_BIT] & ~CFG_I.unregulated;
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      RDATA_O <= 8'h00;
    end else if (RD_I) begin
      RDATA_O <= 8'h00;
      unique case (ADDR_I)
        `SWC_REG_OFFSET_REGCTL: begin
          RDATA_O[`SWC_REGCTL_PM_BIT] <= regpm_reg & ~CFG_I.unregulated;
          RDATA_O[`SWC_REGCTL_RSVD_BIT] <= 1'b1;
        end
        `SWC_REG_OFFSET_STATUS: begin
          RDATA_O[`SWC_STATUS_TO_BIT] <= TO_FLAG_O;
          RDATA_O[`SWC_STATUS_PD_BIT] <= PD_FLAG_O;
        end
        `SWC_REG_OFFSET_CONFIG: RDATA_O[3:0] <= {lp_used_reg, lp_allowed, SLEEPING_O, CPU_CLK_EN_O};
        default: RDATA_O <= 8'h00;
      endcase
    end else begin
      RDATA_O <= 8'h00;
    end
  end

  a_noop_when_pending: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    state_reg == swc_pkg::SWC_RUN && SLEEP_EXEC_I && wake_int && !GIE_I && !wake_rst
    |=> state_reg == swc_pkg::SWC_RUN && $stable(PD_FLAG_O))
    else $error("sleep not a no-op with pending interrupt");
  a_entry_flags: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    state_reg == swc_pkg::SWC_RUN && state_next == swc_pkg::SWC_SLEEP
    |=> !PD_FLAG_O && TO_FLAG_O && WDT_CLR_O)
    else $error("entry flags wrong");
  a_clock_gated: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    state_reg == swc_pkg::SWC_SLEEP |-> !CPU_CLK_EN_O)
    else $error("cpu clock running in sleep");
  a_ost_length: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    $rose(state_reg == swc_pkg::SWC_OST_WAIT) |-> cnt_reg == OST_CNT)
    else $error("oscillator wait length wrong");
  a_wake_clears_wdt: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    state_reg == swc_pkg::SWC_SLEEP && (wake_int || wake_wdt) && !wake_rst |=> WDT_CLR_O)
    else $error("watchdog not cleared on wake");
  a_pins_held: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    state_reg == swc_pkg::SWC_SLEEP && $past(state_reg) == swc_pkg::SWC_SLEEP
    |-> $stable(PIN_OUT_O) && $stable(PIN_OE_O))
    else $error("pins changed in sleep");
  a_reset_wake: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    wake_rst |=> DEV_RESET_O && state_reg == swc_pkg::SWC_RUN)
    else $error("reset wake did not reset");
  a_regulator_lp: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    REG_LP_O |-> lp_used_reg && !CFG_I.unregulated)
    else $error("regulator low power when not allowed");
  a_clock_after_wait: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    state_reg == swc_pkg::SWC_REG_WAIT && cnt_reg > 16'h0001 |=> !CPU_CLK_EN_O)
    else $error("clock back before regulator settled");
  c_int_wake: cover property (@(posedge REF_CLK_I) disable iff (RST_I)
    state_reg == swc_pkg::SWC_SLEEP ##1 state_reg == swc_pkg::SWC_RESUME);
  c_ost_wake: cover property (@(posedge REF_CLK_I) disable iff (RST_I)
    state_reg == swc_pkg::SWC_OST_WAIT ##1 state_reg == swc_pkg::SWC_RESUME);
  c_lp_wake: cover property (@(posedge REF_CLK_I) disable iff (RST_I)
    state_reg == swc_pkg::SWC_REG_WAIT ##1 state_reg == swc_pkg::SWC_RESUME);
  c_vector: cover property (@(posedge REF_CLK_I) disable iff (RST_I) FORCE_VECTOR_O);
  c_wdt_wake: cover property (@(posedge REF_CLK_I) disable iff (RST_I)
    state_reg == swc_pkg::SWC_SLEEP && wake_wdt && !wake_int);
endmodule : swc_top

// file: dv/swc_cpu_model.sv
// Core pipeline and interrupt source model facing the sleep controller
module swc_cpu_model (
  input wire logic clk_i,
  input wire logic cpu_clk_en_i,
  output logic sleep_exec_o,
  output logic [7:0] int_pend_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sleep_exec_o = 1'b0;
    int_pend_o = 8'h00;
  end
  // A gated core fetches nothing, so sleep is only issued while clocked
  task automatic exec_sleep(input logic [7:0] pend);
    @(posedge clk_i);
    sleep_exec_o <= cpu_clk_en_i;
    int_pend_o <= pend;
    @(posedge clk_i);
    sleep_exec_o <= 1'b0;
  endtask : exec_sleep
  // Flags are raw levels; the controller does its own synchronising
  task automatic set_pend(input logic [7:0] pend);
    @(posedge clk_i);
    int_pend_o <= pend;
  endtask : set_pend
endmodule : swc_cpu_model

// file: dv/tb_swc_top.sv
// Self-checking bench for the sleep and wake controller
module tb_swc_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic slp, global_int_enable, wdt_to, lpsafe, adc_rc, wr, rd;
  logic [7:0] pend, ien, pout, poe, wdata;
  logic [7:0] rdata, pin_o, oe_o;
  logic [3:0] addr;
  logic [2:0] t1src;
  swc_pkg::swc_reset_src_t rsrc;
  swc_pkg::swc_cfg_t cfg;
  logic clk_en, sleeping, pd, to, wclr, wrun, drst, pref, fvec, lfosc, t1run, adcrun, reglp;
  logic [15:0] vaddr;
  logic seen_clr, seen_vec;
  int miscompares = 0;
  int num_checks = 0;
  int cnt;
  always #50 clk = ~clk;
  swc_cpu_model i_swc_cpu_model (.clk_i(clk), .cpu_clk_en_i(clk_en), .sleep_exec_o(slp),
    .int_pend_o(pend));
  swc_top i_swc_top (.REF_CLK_I(clk), .RST_I(rst), .SLEEP_EXEC_I(slp), .INT_PEND_I(pend),
    .INT_EN_I(ien), .GIE_I(global_int_enable), .WDT_TIMEOUT_I(wdt_to), .LPSAFE_BLOCK_I(lpsafe),
    .T1_SRC_I(t1src), .ADC_RC_SEL_I(adc_rc), .RST_SRC_I(rsrc), .CFG_I(cfg),
    .PIN_OUT_I(pout), .PIN_OE_I(poe), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
    .RD_I(rd), .RDATA_O(rdata), .CPU_CLK_EN_O(clk_en), .SLEEPING_O(sleeping),
    .PD_FLAG_O(pd), .TO_FLAG_O(to), .WDT_CLR_O(wclr), .WDT_RUN_O(wrun),
    .DEV_RESET_O(drst), .PREFETCH_O(pref), .FORCE_VECTOR_O(fvec), .VECTOR_ADDR_O(vaddr),
    .LFOSC_EN_O(lfosc), .T1_RUN_O(t1run), .ADC_RUN_O(adcrun), .REG_LP_O(reglp),
    .PIN_OUT_O(pin_o), .PIN_OE_O(oe_o));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask : rd_chk
  // Counts cycles until the core clock returns, noting the clear and vector pulses
  task automatic wake(input int limit);
    cnt = 0;
    seen_clr = 1'b0;
    seen_vec = 1'b0;
    while (clk_en !== 1'b1 && cnt < limit) begin
      @(posedge clk);
      #1 cnt++;
      seen_clr = seen_clr | wclr;
    end
    repeat (4) begin
      @(posedge clk);
      #1 seen_vec = seen_vec | fvec;
    end
  endtask : wake
  task automatic t_regs;
    rd_chk(4'h0, 8'h01);
    rd_chk(4'h1, 8'h18);
    rd_chk(4'hF, 8'h00);
    wr_reg(4'h1, 8'h00);
    rd_chk(4'h1, 8'h18);
    wr_reg(4'h0, 8'h03);
    rd_chk(4'h0, 8'h03);
    wr_reg(4'h0, 8'h01);
  endtask : t_regs
  task automatic t_noop;
    ien <= 8'h04;
    i_swc_cpu_model.set_pend(8'h04);
    repeat (3) @(posedge clk);
    i_swc_cpu_model.exec_sleep(8'h04);
    repeat (2) @(posedge clk);
    #1 chk(clk_en, 1'b1);
    chk(pd, 1'b1);
    chk(wclr, 1'b0);
    i_swc_cpu_model.set_pend(8'h00);
    repeat (3) @(posedge clk);
  endtask : t_noop
  // Flag arrives with the sleep itself: sleep completes, then wakes at once
  task automatic t_race;
    i_swc_cpu_model.exec_sleep(8'h04);
    #1 chk(pd, 1'b0);
    chk(to, 1'b1);
    wake(10);
    chk(cnt <= 5, 1'b1);
    chk(seen_clr, 1'b1);
    chk(seen_vec, 1'b0);
    i_swc_cpu_model.set_pend(8'h00);
    repeat (3) @(posedge clk);
  endtask : t_race
  task automatic t_int_wake;
    global_int_enable <= 1'b1;
    i_swc_cpu_model.exec_sleep(8'h02);
    #1 chk(clk_en, 1'b0);
    chk(pref, 1'b1);
    chk(wclr, 1'b1);
    chk(reglp, 1'b0);
    pout <= 8'hA5;
    poe <= 8'h0F;
    repeat (5) @(posedge clk);
    #1 chk(pin_o, 8'h5A);
    chk(oe_o, 8'hF0);
    chk(sleeping, 1'b1);
    chk(lfosc, 1'b1);
    chk(t1run, 1'b1);
    chk(adcrun, 1'b1);
    i_swc_cpu_model.set_pend(8'h06);
    wake(10);
    chk(seen_clr, 1'b1);
    chk(seen_vec, 1'b1);
    chk(vaddr, 16'h0004);
    chk(pin_o, 8'hA5);
    chk(drst, 1'b0);
    i_swc_cpu_model.set_pend(8'h00);
    repeat (3) @(posedge clk);
  endtask : t_int_wake
  task automatic lp_sleep(input int lo, input int hi, input logic lp);
    i_swc_cpu_model.exec_sleep(8'h00);
    #1 chk(reglp, lp);
    i_swc_cpu_model.set_pend(8'h04);
    wake(1400);
    chk(cnt >= lo && cnt <= hi, 1'b1);
    i_swc_cpu_model.set_pend(8'h00);
    repeat (3) @(posedge clk);
  endtask : lp_sleep
  // Crystal start-up and regulator settling are both long; each case is timed
  task automatic t_delays;
    cfg.xtal_mode <= 1'b1;
    wr_reg(4'h0, 8'h03);
    lp_sleep(1224, 1232, 1'b1);
    cfg.two_speed <= 1'b1;
    lp_sleep(200, 208, 1'b1);
    lpsafe <= 1'b1;
    lp_sleep(1, 8, 1'b0);
    lpsafe <= 1'b0;
    cfg.unregulated <= 1'b1;
    rd_chk(4'h0, 8'h01);
    lp_sleep(1, 8, 1'b0);
    cfg <= '0;
    wr_reg(4'h0, 8'h01);
  endtask : t_delays
  task automatic t_wdt;
    cfg.wdt_en_sleep <= 1'b1;
    t1src <= 3'h0;
    adc_rc <= 1'b0;
    i_swc_cpu_model.exec_sleep(8'h00);
    #1 chk(wrun, 1'b1);
    chk(t1run, 1'b0);
    chk(adcrun, 1'b0);
    wdt_to <= 1'b1;
    wake(10);
    chk(cnt <= 5, 1'b1);
    chk(seen_clr, 1'b1);
    chk(to, 1'b0);
    chk(drst, 1'b0);
    wdt_to <= 1'b0;
    t1src <= 3'h1;
    adc_rc <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : t_wdt
  task automatic t_rst;
    i_swc_cpu_model.exec_sleep(8'h00);
    rsrc.external_reset_pin <= 1'b1;
    repeat (5) @(posedge clk);
    #1 chk(sleeping, 1'b1);
    rsrc.por <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk(drst, 1'b1);
    chk(clk_en, 1'b1);
    chk(pd & to, 1'b1);
    rsrc <= '0;
    repeat (4) @(posedge clk);
  endtask : t_rst
  task automatic finish_test;
    if (miscompares == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test
  initial begin
    #3000000;
    miscompares++;
    finish_test();
  end
  initial begin
    global_int_enable <= 1'b0;
    wdt_to <= 1'b0;
    lpsafe <= 1'b0;
    adc_rc <= 1'b1;
    wr <= 1'b0;
    rd <= 1'b0;
    ien <= 8'h00;
    pout <= 8'h5A;
    poe <= 8'hF0;
    wdata <= 8'h00;
    addr <= 4'h0;
    t1src <= 3'h1;
    rsrc <= '0;
    cfg <= '0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_noop();
    t_race();
    t_int_wake();
    t_delays();
    t_wdt();
    t_rst();
    finish_test();
  end
endmodule : tb_swc_top
